// ---- shared/tcsf_pkg.sv ----
// ************************************************************
// Shared constants and carriers for the channel status block.
// ************************************************************
package tcsf_pkg;

  // Number of timer channels and the counter width.
  localparam int NUM_CH = 6;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;

  // Counter end values that mark a wrap.
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_MIN = 16'h0000;

  // Register byte offsets.
  localparam logic [7:0] STATUS_BASE = 8'h00;
  localparam logic [7:0] ENABLE_BASE = 8'h18;
  localparam logic [7:0] EVT_STAT_OFS = 8'h30;
  localparam logic [7:0] EVT_MASK_OFS = 8'h34;
  localparam logic [7:0] CH_STRIDE = 8'h04;

  // Bit positions inside a channel status byte.
  localparam int DIR_BIT = 7;
  localparam int RSV_BIT = 6;
  localparam int DOWN_BIT = 5;
  localparam int UP_BIT = 4;

  // Channels that own a count direction and an underflow flag.
  localparam logic [5:0] CH_HAS_DOWN = 6'h36;

  // Reset values of the direction bit and the event flags.
  localparam logic DIR_RESET = 1'b1;
  localparam logic FLAG_RESET = 1'b0;

  // Event status layout: wrap-up events low, wrap-down events high.
  localparam int EVT_W = 2 * NUM_CH;
  localparam int EVT_DOWN_LSB = NUM_CH;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // What one channel of the counter logic tells this block.
  typedef struct packed {
    logic [15:0] count;
    logic count_up;
    logic phase_mode;
  } tcsf_chan_in_s;

  // One register write as handed from the bus slave.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } tcsf_wr_s;

endpackage

// ---- rtl/tcsf_axil_slave.sv ----
`timescale 1ns/10ps
// ************************************************************
// AXI4-Lite slave front end: turns handshakes into strobes.
// ************************************************************
module tcsf_axil_slave (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Write address and data channels.
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // Write response channel.
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // Read channels.
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Register side.
  output logic o_wr,
  output tcsf_pkg::tcsf_wr_s o_wr_req,
  input wire logic i_wr_err,
  output logic o_rd,
  output logic [7:0] o_rd_addr,
  input wire logic [31:0] i_rd_data,
  input wire logic i_rd_err
);

  logic aw_held_reg; // Write address captured, waiting for data.
  logic w_held_reg; // Write data captured, waiting for address.
  logic wr_go;

  // Both halves present and no response pending: perform the write.
  assign wr_go = aw_held_reg && w_held_reg && !o_bvalid;
  assign o_wr = wr_go;
  // A read is taken in the cycle its address handshake completes.
  assign o_rd = o_arready;
  assign o_rd_addr = i_araddr;

  // Address and data are taken in either order, one beat each.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_wr_req <= '0;
    end else begin
      o_awready <= i_awvalid && !aw_held_reg && !o_awready;
      o_wready <= i_wvalid && !w_held_reg && !o_wready;
      if (o_awready) begin
        aw_held_reg <= 1'b1;
        o_wr_req.addr <= i_awaddr;
      end else if (wr_go) begin
        aw_held_reg <= 1'b0;
      end
      if (o_wready) begin
        w_held_reg <= 1'b1;
        o_wr_req.data <= i_wdata;
        o_wr_req.strb <= i_wstrb;
      end else if (wr_go) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // Write response stands until the master accepts it.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_bvalid <= 1'b0;
      o_bresp <= tcsf_pkg::RESP_OKAY;
    end else if (wr_go) begin
      o_bvalid <= 1'b1;
      o_bresp <= i_wr_err ? tcsf_pkg::RESP_SLVERR : tcsf_pkg::RESP_OKAY;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Read: one-cycle arready pulse, data registered with it.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= tcsf_pkg::RESP_OKAY;
    end else begin
      o_arready <= i_arvalid && !o_arready && !o_rvalid;
      if (o_arready) begin
        o_rvalid <= 1'b1;
        o_rdata <= i_rd_data;
        o_rresp <= i_rd_err ? tcsf_pkg::RESP_SLVERR : tcsf_pkg::RESP_OKAY;
      end else if (i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ---- rtl/tcsf_chan_flags.sv ----
`timescale 1ns/10ps
// ************************************************************
// Status flags of one timer channel.
// ************************************************************
module tcsf_chan_flags #(
  parameter bit HAS_DOWN = 1'b1 // Channel owns direction and underflow.
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Counter state of this channel.
  input wire tcsf_pkg::tcsf_chan_in_s i_chan,
  // Software access to this channel's status byte.
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  // Status byte and wrap event pulses.
  output logic [7:0] o_status,
  output logic o_down_ev,
  output logic o_up_ev
);

  logic [15:0] prev_reg; // Counter value one cycle ago.
  logic prev_ok_reg; // Low until prev_reg holds a real sample.
  logic dir_reg; // Count direction flag.
  logic down_reg; // Wrap down flag.
  logic up_reg; // Wrap up flag.
  logic down_armed_reg; // Wrap down flag was read as one.
  logic up_armed_reg; // Wrap up flag was read as one.
  logic down_clr;
  logic up_clr;

  // A wrap is seen as an end value followed by the other end value.
  assign o_up_ev = prev_ok_reg && prev_reg == tcsf_pkg::CNT_MAX
    && i_chan.count == tcsf_pkg::CNT_MIN;
  assign o_down_ev = HAS_DOWN && i_chan.phase_mode && prev_ok_reg
    && prev_reg == tcsf_pkg::CNT_MIN
    && i_chan.count == tcsf_pkg::CNT_MAX;

  // Only a zero written after a read of one clears; a one is ignored.
  assign down_clr = i_wr && !i_wdata[tcsf_pkg::DOWN_BIT]
    && down_armed_reg;
  assign up_clr = i_wr && !i_wdata[tcsf_pkg::UP_BIT]
    && up_armed_reg;

  // Counter history for the wrap detector.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      prev_reg <= tcsf_pkg::CNT_MIN;
      prev_ok_reg <= 1'b0;
    end else begin
      prev_reg <= i_chan.count;
      prev_ok_reg <= 1'b1;
    end
  end

  // Direction follows the counter; it is read-only to software.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      dir_reg <= tcsf_pkg::DIR_RESET;
    end else begin
      dir_reg <= i_chan.count_up;
    end
  end

  // Event flags: a set in the clearing cycle wins over the clear.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      down_reg <= tcsf_pkg::FLAG_RESET;
      up_reg <= tcsf_pkg::FLAG_RESET;
    end else begin
      if (o_down_ev) begin
        down_reg <= 1'b1;
      end else if (down_clr) begin
        down_reg <= 1'b0;
      end
      if (o_up_ev) begin
        up_reg <= 1'b1;
      end else if (up_clr) begin
        up_reg <= 1'b0;
      end
    end
  end

  // A read arms the clear only for flags it saw as one.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      down_armed_reg <= 1'b0;
      up_armed_reg <= 1'b0;
    end else begin
      if (down_clr) begin
        down_armed_reg <= 1'b0;
      end else if (i_rd) begin
        down_armed_reg <= down_reg;
      end
      if (up_clr) begin
        up_armed_reg <= 1'b0;
      end else if (i_rd) begin
        up_armed_reg <= up_reg;
      end
    end
  end

  // Status byte; reserved bits read fixed and the low nibble is zero.
  always_comb begin
    o_status = '0;
    o_status[tcsf_pkg::DIR_BIT] = HAS_DOWN ? dir_reg : 1'b1;
    o_status[tcsf_pkg::RSV_BIT] = 1'b1;
    o_status[tcsf_pkg::DOWN_BIT] = HAS_DOWN && down_reg;
    o_status[tcsf_pkg::UP_BIT] = up_reg;
  end

endmodule

// ---- rtl/tcsf_top.sv ----
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
// ************************************************************
// Overview of operation
// - Six status registers, one per channel.
// - Bit 7 shows count direction, read-only.
// - Channels 0 and 3: bit 7 reads one.
// - Bit 6 always reads one, ignores writes.
// - Phase mode underflow wrap sets bit 5.
// - Channels 0 and 3: bit 5 reads zero.
// - Underflow clears by zero write after read.
// - Overflow wrap sets bit 4, every channel.
// - Overflow clears by zero write after read.
// - Underflow request when flag and enable set.
// - Overflow request when flag and enable set.
// ************************************************************
module tcsf_top (
  // Clock and reset.
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  // Counter state of each channel.
  input wire tcsf_pkg::tcsf_chan_in_s [5:0] I_CHAN,
  // AXI4-Lite write address and data.
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_WVALID,
  output logic O_WREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  // AXI4-Lite write response.
  output logic O_BVALID,
  input wire logic I_BREADY,
  output logic [1:0] O_BRESP,
  // AXI4-Lite read.
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  input wire logic [7:0] I_ARADDR,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  // Interrupt requests.
  output logic [5:0] O_WRAP_DOWN_IRQ,
  output logic [5:0] O_WRAP_UP_IRQ,
  output logic O_IRQ
);

  // ************************************************************
  // Address decode helpers
  // ************************************************************

  // True when the address falls on a word of a six-word bank.
  function automatic logic bank_hit(input logic [7:0] addr,
                                    input logic [7:0] base);
    logic [7:0] ofs;
    ofs = addr - base;
    bank_hit = addr >= base && addr[1:0] == 2'h0
      && ofs < 8'(tcsf_pkg::NUM_CH) * tcsf_pkg::CH_STRIDE;
  endfunction

  // Channel index of a word inside a bank.
  function automatic logic [2:0] bank_ch(input logic [7:0] addr,
                                         input logic [7:0] base);
    logic [7:0] ofs;
    ofs = addr - base;
    bank_ch = ofs[4:2];
  endfunction

  // ************************************************************
  // Bus slave
  // ************************************************************

  logic wr; // One-cycle write strobe.
  tcsf_pkg::tcsf_wr_s wr_req; // Address, data and strobes of it.
  logic wr_err; // Write address maps to nothing.
  logic rd; // One-cycle read strobe.
  logic [7:0] rd_addr; // Address of the read.
  logic [31:0] rd_data; // Data for the read, combinational.
  logic rd_err; // Read address maps to nothing.

  // The slave holds every bus output in a flip-flop.
  tcsf_axil_slave u_slave (
    .i_clk(I_CORE_CLK),
    .i_rst_b(I_RST_B),
    .i_awvalid(I_AWVALID),
    .o_awready(O_AWREADY),
    .i_awaddr(I_AWADDR),
    .i_wvalid(I_WVALID),
    .o_wready(O_WREADY),
    .i_wdata(I_WDATA),
    .i_wstrb(I_WSTRB),
    .o_bvalid(O_BVALID),
    .i_bready(I_BREADY),
    .o_bresp(O_BRESP),
    .i_arvalid(I_ARVALID),
    .o_arready(O_ARREADY),
    .i_araddr(I_ARADDR),
    .o_rvalid(O_RVALID),
    .i_rready(I_RREADY),
    .o_rdata(O_RDATA),
    .o_rresp(O_RRESP),
    .o_wr(wr),
    .o_wr_req(wr_req),
    .i_wr_err(wr_err),
    .o_rd(rd),
    .o_rd_addr(rd_addr),
    .i_rd_data(rd_data),
    .i_rd_err(rd_err)
  );

  // Decoded targets of the current write and read.
  logic wr_status_hit;
  logic wr_enable_hit;
  logic [2:0] wr_ch;
  logic rd_status_hit;
  logic rd_enable_hit;
  logic [2:0] rd_ch;

  assign wr_status_hit = bank_hit(wr_req.addr, tcsf_pkg::STATUS_BASE);
  assign wr_enable_hit = bank_hit(wr_req.addr, tcsf_pkg::ENABLE_BASE);
  assign wr_ch = bank_ch(wr_req.addr, wr_status_hit ?
    tcsf_pkg::STATUS_BASE : tcsf_pkg::ENABLE_BASE);
  assign rd_status_hit = bank_hit(rd_addr, tcsf_pkg::STATUS_BASE);
  assign rd_enable_hit = bank_hit(rd_addr, tcsf_pkg::ENABLE_BASE);
  assign rd_ch = bank_ch(rd_addr, rd_status_hit ?
    tcsf_pkg::STATUS_BASE : tcsf_pkg::ENABLE_BASE);

  // Writes to the event status and mask words.
  logic wr_evt_stat;
  logic wr_evt_mask;
  assign wr_evt_stat = wr && wr_req.addr == tcsf_pkg::EVT_STAT_OFS;
  assign wr_evt_mask = wr && wr_req.addr == tcsf_pkg::EVT_MASK_OFS;
  assign wr_err = !(wr_status_hit || wr_enable_hit
    || wr_req.addr == tcsf_pkg::EVT_STAT_OFS
    || wr_req.addr == tcsf_pkg::EVT_MASK_OFS);

  // ************************************************************
  // Channel flags
  // ************************************************************

  logic [7:0] status [6]; // Status byte of each channel.
  logic [5:0] down_ev; // Wrap down event pulses.
  logic [5:0] up_ev; // Wrap up event pulses.
  logic [5:0] down_en_reg; // Wrap down request enables.
  logic [5:0] up_en_reg; // Wrap up request enables.

  // One independent flag block per channel; the status byte lane is
  // only touched when byte strobe zero is set.
  for (genvar ch = 0; ch < tcsf_pkg::NUM_CH; ch++) begin : g_ch
    tcsf_chan_flags #(
      .HAS_DOWN(tcsf_pkg::CH_HAS_DOWN[ch])
    ) u_flags (
      .i_clk(I_CORE_CLK),
      .i_rst_b(I_RST_B),
      .i_chan(I_CHAN[ch]),
      .i_rd(rd && rd_status_hit && rd_ch == 3'(ch)),
      .i_wr(wr && wr_status_hit && wr_ch == 3'(ch)
        && wr_req.strb[0]),
      .i_wdata(wr_req.data[7:0]),
      .o_status(status[ch]),
      .o_down_ev(down_ev[ch]),
      .o_up_ev(up_ev[ch])
    );
  end

  // Request enables; the wrap down enable does not exist in channels
  // without an underflow flag and stays zero there.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      down_en_reg <= '0;
      up_en_reg <= '0;
    end else if (wr && wr_enable_hit && wr_req.strb[0]) begin
      down_en_reg[wr_ch] <= wr_req.data[tcsf_pkg::DOWN_BIT]
        && tcsf_pkg::CH_HAS_DOWN[wr_ch];
      up_en_reg[wr_ch] <= wr_req.data[tcsf_pkg::UP_BIT];
    end
  end

  // Per-channel requests stand while flag and enable are both set.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_WRAP_DOWN_IRQ <= '0;
      O_WRAP_UP_IRQ <= '0;
    end else begin
      for (int ch = 0; ch < tcsf_pkg::NUM_CH; ch++) begin
        O_WRAP_DOWN_IRQ[ch] <= status[ch][tcsf_pkg::DOWN_BIT]
          && down_en_reg[ch] && tcsf_pkg::CH_HAS_DOWN[ch];
        O_WRAP_UP_IRQ[ch] <= status[ch][tcsf_pkg::UP_BIT]
          && up_en_reg[ch];
      end
    end
  end

  // ************************************************************
  // Summary interrupt
  // ************************************************************

  logic [11:0] evt_stat_reg; // Sticky wrap events, write one to clear.
  logic [11:0] evt_mask_reg; // Events allowed onto the summary line.
  logic [11:0] evt_set;
  logic [11:0] evt_clr;

  // The summary copy is separate from the channel flags so a driver
  // can use it without the read-then-write-zero dance.
  assign evt_set = {down_ev, up_ev};
  assign evt_clr = wr_evt_stat ? wr_req.data[11:0] : '0;

  // A new event in the clearing cycle stays set.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      evt_stat_reg <= '0;
    end else begin
      evt_stat_reg <= (evt_stat_reg & ~evt_clr) | evt_set;
    end
  end

  // Mask register, each of the two low byte lanes written under its own strobe.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      evt_mask_reg <= '0;
    end else if (wr_evt_mask) begin
      if (wr_req.strb[0]) begin
        evt_mask_reg[7:0] <= wr_req.data[7:0];
      end
      if (wr_req.strb[1]) begin
        evt_mask_reg[11:8] <= wr_req.data[11:8];
      end
    end
  end

  // Level output, high while any unmasked event is pending.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_IRQ <= 1'b0;
    end else begin
      O_IRQ <= |(evt_stat_reg & evt_mask_reg);
    end
  end

  // ************************************************************
  // Read multiplexer
  // ************************************************************

  // Unmapped addresses answer zero with an error response.
  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    if (rd_status_hit) begin
      rd_data[7:0] = status[rd_ch];
    end else if (rd_enable_hit) begin
      rd_data[tcsf_pkg::DOWN_BIT] = down_en_reg[rd_ch];
      rd_data[tcsf_pkg::UP_BIT] = up_en_reg[rd_ch];
    end else if (rd_addr == tcsf_pkg::EVT_STAT_OFS) begin
      rd_data[11:0] = evt_stat_reg;
    end else if (rd_addr == tcsf_pkg::EVT_MASK_OFS) begin
      rd_data[11:0] = evt_mask_reg;
    end else begin
      rd_err = 1'b1;
    end
  end

endmodule

// ---- tb/tcsf_monitor.sv ----
`timescale 1ns/10ps
// ****
// Port checker of the channel status block.
// ****
module tcsf_monitor (
  // Clock and reset.
  input wire logic I_CORE_CLK,
  input wire logic I_RST_B,
  // Counter state and bus handshakes.
  input wire tcsf_pkg::tcsf_chan_in_s [5:0] I_CHAN,
  input wire logic I_ARVALID,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_BREADY,
  input wire logic I_RREADY,
  input wire logic O_ARREADY,
  input wire logic O_BVALID,
  input wire logic [1:0] O_BRESP,
  input wire logic O_RVALID,
  input wire logic [31:0] O_RDATA,
  // Interrupt requests.
  input wire logic [5:0] O_WRAP_DOWN_IRQ,
  input wire logic [5:0] O_WRAP_UP_IRQ
);
  default clocking @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_B);
  // Last counts, so that a wrap is visible at the ports.
  logic [5:0][15:0] cnt_reg;
  // Address of the read in flight.
  logic [7:0] ra_reg;
  // Wrap events at this edge.
  logic [5:0] up_w;
  logic [5:0] dn_w;
  // Keep the previous count of every channel.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cnt_reg <= '0;
    end else begin
      for (int c = 0; c < 6; c++) begin
        cnt_reg[c] <= I_CHAN[c].count;
      end
    end
  end
  // Capture the address of each accepted read.
  always_ff @(posedge I_CORE_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ra_reg <= 8'hff;
    end else if (I_ARVALID && O_ARREADY) begin
      ra_reg <= I_ARADDR;
    end
  end
  // Mode is ignored here, which only widens the accepted causes.
  always_comb begin
    for (int c = 0; c < 6; c++) begin
      up_w[c] = cnt_reg[c] == 16'hffff && I_CHAN[c].count == 16'h0000;
      dn_w[c] = cnt_reg[c] == 16'h0000 && I_CHAN[c].count == 16'hffff;
    end
  end
  // A write answer stood in the last two edges.
  sequence s_wr;
    $past(O_BVALID) || $past(O_BVALID, 2);
  endsequence
  // A wrap one to three edges back.
  sequence s_up;
    $past(|up_w) || $past(|up_w, 2) || $past(|up_w, 3);
  endsequence
  sequence s_dn;
    $past(|dn_w) || $past(|dn_w, 2) || $past(|dn_w, 3);
  endsequence
  AST_B_HOLD: assert property (
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write answer dropped early");
  AST_R_HOLD: assert property (
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read answer dropped early");
  AST_AR_ANSWER: assert property (
    I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  AST_BIT6_ONE: assert property (
    O_RVALID && ra_reg < 8'h18 && ra_reg[1:0] == 2'h0
    |-> O_RDATA[6] && O_RDATA[3:0] == 4'h0)
    else $error("status fixed bits wrong");
  AST_CH03_BITS: assert property (
    O_RVALID && (ra_reg == 8'h00 || ra_reg == 8'h0c)
    |-> O_RDATA[7:5] == 3'b110)
    else $error("channel 0 or 3 fixed bits wrong");
  AST_NO_DN_CH03: assert property (
    !O_WRAP_DOWN_IRQ[0] && !O_WRAP_DOWN_IRQ[3])
    else $error("underflow request on channel 0 or 3");
  AST_UP_RISE: assert property (
    |(O_WRAP_UP_IRQ & ~$past(O_WRAP_UP_IRQ)) |-> s_up or s_wr)
    else $error("overflow request without cause");
  AST_DN_RISE: assert property (
    |(O_WRAP_DOWN_IRQ & ~$past(O_WRAP_DOWN_IRQ)) |-> s_dn or s_wr)
    else $error("underflow request without cause");
  AST_UP_FALL: assert property (
    |(~O_WRAP_UP_IRQ & $past(O_WRAP_UP_IRQ)) |-> s_wr)
    else $error("overflow request fell without write");
  AST_DN_FALL: assert property (
    |(~O_WRAP_DOWN_IRQ & $past(O_WRAP_DOWN_IRQ)) |-> s_wr)
    else $error("underflow request fell without write");
endmodule
bind tcsf_top tcsf_monitor u_mon (
  .I_CORE_CLK, .I_RST_B, .I_CHAN, .I_ARVALID, .I_ARADDR, .I_BREADY,
  .I_RREADY, .O_ARREADY, .O_BVALID, .O_BRESP, .O_RVALID, .O_RDATA,
  .O_WRAP_DOWN_IRQ, .O_WRAP_UP_IRQ
);

// ---- tb/tcsf_top_tb.sv ----
`timescale 1ns/10ps
// ****
// Self-checking bench of the channel status block.
// ****
module tcsf_top_tb;
  // Design ports.
  logic I_CORE_CLK, I_RST_B, I_AWVALID, I_WVALID, I_BREADY;
  logic I_ARVALID, I_RREADY, O_AWREADY, O_WREADY, O_BVALID;
  logic O_ARREADY, O_RVALID, O_IRQ;
  tcsf_pkg::tcsf_chan_in_s [5:0] I_CHAN;
  logic [7:0] I_AWADDR, I_ARADDR;
  logic [31:0] I_WDATA, O_RDATA;
  logic [3:0] I_WSTRB;
  logic [1:0] O_BRESP, O_RRESP;
  logic [5:0] O_WRAP_DOWN_IRQ, O_WRAP_UP_IRQ;
  // Expected answers, oldest first.
  logic [33:0] rd_q[$];
  logic [1:0] wr_q[$];
  // Tallies, random state and direction pattern.
  int err_total = 0;
  int compares = 0;
  logic [31:0] lfsr_reg = 32'h24cd7641;
  logic [5:0] dirs = 6'h3f;
  tcsf_top uut (
    .I_CORE_CLK, .I_RST_B, .I_CHAN, .I_AWVALID, .O_AWREADY, .I_AWADDR,
    .I_WVALID, .O_WREADY, .I_WDATA, .I_WSTRB, .O_BVALID, .I_BREADY,
    .O_BRESP, .I_ARVALID, .O_ARREADY, .I_ARADDR, .O_RVALID, .I_RREADY,
    .O_RDATA, .O_RRESP, .O_WRAP_DOWN_IRQ, .O_WRAP_UP_IRQ, .O_IRQ
  );
  // Free-running core clock.
  initial begin
    I_CORE_CLK = 1'b0;
    forever #5 I_CORE_CLK = ~I_CORE_CLK;
  end
  // Next pseudo-random word.
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Status word that channel c should show with flags f.
  function automatic logic [31:0] st(input int c, input logic [1:0] f);
    if (tcsf_pkg::CH_HAS_DOWN[c]) begin
      return {24'h0, dirs[c], 1'b1, f, 4'h0};
    end
    return {24'h0, 3'b110, f[0], 4'h0};
  endfunction
  // All request outputs in one word.
  function automatic logic [33:0] irqs();
    return {21'h0, O_IRQ, O_WRAP_DOWN_IRQ, O_WRAP_UP_IRQ};
  endfunction
  task automatic cmp(input string n, input logic [33:0] e,
                     input logic [33:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // A wait that ran out ends the run.
  task automatic give_up();
    err_total++;
    $display("unexpected wait expected answer seen none");
    test_done();
  endtask
  // Drive every counter with one value and mode.
  task automatic drv(input logic [15:0] v, input logic ph);
    @(posedge I_CORE_CLK);
    for (int c = 0; c < 6; c++) begin
      I_CHAN[c] <= '{count: v, count_up: dirs[c], phase_mode: ph};
    end
  endtask
  // A random count that is never an end value, so no wrap.
  task automatic calm(input logic ph);
    lfsr_reg = lfsr(lfsr_reg);
    drv({1'b0, lfsr_reg[14:1], 1'b1}, ph);
  endtask
  // Let request outputs follow, then look between edges.
  task automatic settle();
    repeat (3) @(posedge I_CORE_CLK);
    @(negedge I_CORE_CLK);
  endtask
  // Register write; bready is raised once bvalid is seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = tcsf_pkg::RESP_OKAY);
    int n = 0;
    @(posedge I_CORE_CLK);
    wr_q.push_back(e);
    I_AWVALID <= 1'b1;
    I_AWADDR <= a;
    I_WVALID <= 1'b1;
    I_WDATA <= d;
    do begin
      @(posedge I_CORE_CLK);
      if (O_AWREADY) I_AWVALID <= 1'b0;
      if (O_WREADY) I_WVALID <= 1'b0;
      if (O_BVALID && !I_BREADY) I_BREADY <= 1'b1;
      n++;
    end while (!(O_BVALID && I_BREADY) && n < 100);
    I_BREADY <= 1'b0;
    if (n >= 100) give_up();
  endtask
  // Register read; the late rready makes the answer stand a cycle.
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e = tcsf_pkg::RESP_OKAY);
    int n = 0;
    @(posedge I_CORE_CLK);
    rd_q.push_back({d, e});
    I_ARVALID <= 1'b1;
    I_ARADDR <= a;
    do begin
      @(posedge I_CORE_CLK);
      if (O_ARREADY) I_ARVALID <= 1'b0;
      if (O_RVALID && !I_RREADY) I_RREADY <= 1'b1;
      n++;
    end while (!(O_RVALID && I_RREADY) && n < 100);
    I_RREADY <= 1'b0;
    if (n >= 100) give_up();
  endtask
  // Compare each bus answer with the oldest note.
  always @(posedge I_CORE_CLK) begin
    if (O_RVALID && I_RREADY) begin
      cmp("read", rd_q.pop_front(), {O_RDATA, O_RRESP});
    end
    if (O_BVALID && I_BREADY) begin
      cmp("bresp", {32'h0, wr_q.pop_front()}, {32'h0, O_BRESP});
    end
  end
  // ****
  // Main sequence.
  // ****
  initial begin
    I_RST_B = 1'b0;
    I_AWVALID = 1'b0;
    I_WVALID = 1'b0;
    I_BREADY = 1'b0;
    I_ARVALID = 1'b0;
    I_RREADY = 1'b0;
    I_AWADDR = 8'h00;
    I_ARADDR = 8'h00;
    I_WDATA = 32'h0;
    I_WSTRB = 4'hf;
    I_CHAN = {6{16'h0100, 1'b1, 1'b0}};
    repeat (6) @(posedge I_CORE_CLK);
    I_RST_B <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      rd(8'(4 * c), st(c, 2'b00));
      rd(8'(8'h18 + 4 * c), 32'h0);
      wr(8'(4 * c), 32'hff);
      rd(8'(4 * c), st(c, 2'b00));
    end
    rd(8'h30, 32'h0);
    rd(8'h34, 32'h0);
    $display("test reset_values done");
    lfsr_reg = lfsr(lfsr_reg);
    dirs = lfsr_reg[5:0];
    drv(16'h0000, 1'b0);
    drv(16'hffff, 1'b0);
    calm(1'b0);
    for (int c = 0; c < 6; c++) begin
      rd(8'(4 * c), st(c, 2'b00));
    end
    $display("test direction done");
    drv(16'hffff, 1'b1);
    drv(16'h0000, 1'b1);
    drv(16'hffff, 1'b1);
    calm(1'b1);
    settle();
    cmp("irq", 34'h0, irqs());
    for (int c = 0; c < 6; c++) begin
      wr(8'(4 * c), 32'h00);
      wr(8'(4 * c), 32'hff);
      wr(8'(8'h18 + 4 * c), 32'h30);
      rd(8'(8'h18 + 4 * c), tcsf_pkg::CH_HAS_DOWN[c] ? 32'h30 : 32'h10);
    end
    settle();
    cmp("irq", {22'h0, 6'h36, 6'h3f}, irqs());
    wr(8'h34, 32'hfff);
    settle();
    cmp("irq", {21'h1, 6'h36, 6'h3f}, irqs());
    rd(8'h30, 32'hdbf);
    for (int c = 0; c < 6; c++) begin
      rd(8'(4 * c), st(c, {tcsf_pkg::CH_HAS_DOWN[c], 1'b1}));
    end
    // A zero written without byte lane zero must not clear armed flags.
    I_WSTRB <= 4'he;
    wr(8'h04, 32'h00);
    I_WSTRB <= 4'hf;
    rd(8'h04, st(1, 2'b11));
    for (int c = 0; c < 6; c++) begin
      wr(8'(4 * c), 32'h00);
      rd(8'(4 * c), st(c, 2'b00));
    end
    settle();
    cmp("irq", {21'h1, 12'h0}, irqs());
    wr(8'h30, 32'hfff);
    settle();
    cmp("irq", 34'h0, irqs());
    rd(8'h40, 32'h0, tcsf_pkg::RESP_SLVERR);
    wr(8'h40, 32'h0, tcsf_pkg::RESP_SLVERR);
    // Wraps with the enables already set raise the requests directly.
    drv(16'hffff, 1'b1);
    drv(16'h0000, 1'b1);
    drv(16'hffff, 1'b1);
    calm(1'b1);
    settle();
    cmp("irq", {21'h1, 6'h36, 6'h3f}, irqs());
    $display("test flags done");
    test_done();
  end
  // Verdict and end of run.
  task automatic test_done();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
endmodule
